// ==== verilog/lane_mask_defs.vh ====
`ifndef LANE_MASK_DEFS_VH
`define LANE_MASK_DEFS_VH

// Build-time data width: 8, 9, 18 or 36
`define DATA_W_DEFAULT 18

// Word address width of the small model array (burst base address)
`define ADDR_W 6

// Write beat buffer
`define FIFO_DEPTH 32
`define FIFO_PTR_W 5

// Burst word offsets
`define BEAT_FIRST 1'b0
`define BEAT_SECOND 1'b1

// Write sequencer states
`define WR_IDLE 2'b00
`define WR_SECOND 2'b01
`define WR_PUSH0 2'b10
`define WR_PUSH1 2'b11

// Read launcher states
`define RD_IDLE 3'b000
`define RD_ARM 3'b001
`define RD_WORD0 3'b010
`define RD_WORD1 3'b011
`define RD_TAIL 3'b100

`endif

// ==== verilog/beat_fifo.v ====
`timescale 1ns/1ps
`default_nettype none
module beat_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter PTR_W = 5
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr_r;
	reg [PTR_W-1:0] rd_ptr_r;
	reg [PTR_W:0] count_r;
	wire push;
	wire pop;

	assign in_ready = (count_r != DEPTH[PTR_W:0]);
	assign out_valid = (count_r != {(PTR_W+1){1'b0}});
	assign out_data = store[rd_ptr_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge core_clk)
	begin
		if (push)
			store[wr_ptr_r] <= in_data;
	end

	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_r <= {PTR_W{1'b0}};
			rd_ptr_r <= {PTR_W{1'b0}};
			count_r <= {(PTR_W+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push & ~pop)
				count_r <= count_r + 1'b1;
			else if (pop & ~push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule // beat_fifo
`default_nettype wire

// ==== verilog/burst_write_lane_masking.v ====
// Contract
// - 18-bit: select 0 gates bits 8..0, select 1 gates bits 17..9.
// - 8-bit: nibble select 0 gates bits 3..0, select 1 bits 7..4.
// - 9-bit: one select gates all nine bits of a beat.
// - 36-bit: four 9-bit lanes, each with its own active-low select.
// - Selects sampled per beat: first on positive, second on negative clock rise.
// - All selects high: beat writes nothing, burst still proceeds.
// - Power-up with ports deselected and read outputs high impedance.
// - First beat goes to base address plus 0, second to plus 1.
// - Write data registered on both input clock rises, one beat each.
// - Read data launched on output clock rises, input clocks in single clock mode.
// - Write starts on positive rise with port select low; address on negative rise.
`timescale 1ns/1ps
`default_nettype none
`include "lane_mask_defs.vh"
module burst_write_lane_masking #(
	parameter DATA_W = `DATA_W_DEFAULT
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Input clock pair, sampled on core_clk
	input wire in_clk_pos,
	input wire in_clk_neg,
	// Output clock pair, also the single clock mode strap
	input wire out_clk_pos,
	input wire out_clk_neg,
	// Port selects
	input wire write_port_select_n,
	input wire read_port_select_n,
	// Shared address and write data
	input wire [`ADDR_W-1:0] address,
	input wire [DATA_W-1:0] write_data,
	input wire [((DATA_W == 36) ? 4 : ((DATA_W == 9) ? 1 : 2))-1:0] lane_write_select_n,
	// Read data pins
	output reg [DATA_W-1:0] read_data,
	output reg read_data_oe,
	// Write buffer status
	output reg write_ready,
	output reg write_dropped
);
	localparam LANES = (DATA_W == 36) ? 4 : ((DATA_W == 9) ? 1 : 2);
	localparam LANE_W = DATA_W / LANES;
	localparam ADDR_W = `ADDR_W;
	localparam ENT_W = ADDR_W + 1 + LANES + DATA_W;

	// Array word index is {base address, beat}
	reg [DATA_W-1:0] mem [0:(1 << (ADDR_W + 1))-1];

	// Edge detection of the slow interface clocks
	reg kpos_d_r;
	reg kneg_d_r;
	reg cpos_d_r;
	reg cneg_d_r;
	wire kpos_rise;
	wire kneg_rise;
	wire opos_rise;
	wire oneg_rise;

	// Strap capture
	reg strap_done_r;
	reg single_clk_r;

	// Write sequencer
	reg [1:0] wr_state_r;
	reg [1:0] wr_state_nxt;
	reg [DATA_W-1:0] beat0_data_r;
	reg [LANES-1:0] beat0_sel_r;
	reg [DATA_W-1:0] beat1_data_r;
	reg [LANES-1:0] beat1_sel_r;
	reg [ADDR_W-1:0] wr_addr_r;
	reg push_valid;
	reg [ENT_W-1:0] push_entry;
	wire push_ready;

	// Drain into the array
	wire drain_valid;
	wire drain_ready;
	wire [ENT_W-1:0] drain_entry;
	wire [ADDR_W:0] drain_idx;
	wire [LANES-1:0] drain_sel;
	wire [DATA_W-1:0] drain_data;
	reg [DATA_W-1:0] lane_mask;
	wire [DATA_W-1:0] merged;

	// Read launcher
	reg [2:0] rd_state_r;
	reg [2:0] rd_state_nxt;
	reg [ADDR_W-1:0] rd_addr_r;
	wire rd_fetch;
	wire rd_start;
	integer i;

	assign kpos_rise = in_clk_pos & ~kpos_d_r;
	assign kneg_rise = in_clk_neg & ~kneg_d_r;
	// Input clock pair replaces the output pair in single clock mode
	assign opos_rise = single_clk_r ? kpos_rise : (out_clk_pos & ~cpos_d_r);
	assign oneg_rise = single_clk_r ? kneg_rise : (out_clk_neg & ~cneg_d_r);

	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			kpos_d_r <= 1'b0;
			kneg_d_r <= 1'b0;
			cpos_d_r <= 1'b0;
			cneg_d_r <= 1'b0;
		end
		else
		begin
			kpos_d_r <= in_clk_pos;
			kneg_d_r <= in_clk_neg;
			cpos_d_r <= out_clk_pos;
			cneg_d_r <= out_clk_neg;
		end
	end

	// Strap read once, on the first edge after reset release
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			strap_done_r <= 1'b0;
			single_clk_r <= 1'b0;
		end
		else if (!strap_done_r)
		begin
			strap_done_r <= 1'b1;
			single_clk_r <= out_clk_pos & out_clk_neg;
		end
	end

	always @*
	begin
		wr_state_nxt = wr_state_r;
		case (wr_state_r)
			`WR_IDLE:
			begin
				if (kpos_rise && !write_port_select_n)
					wr_state_nxt = `WR_SECOND;
			end
			`WR_SECOND:
			begin
				if (kneg_rise)
					wr_state_nxt = `WR_PUSH0;
			end
			`WR_PUSH0:
				wr_state_nxt = `WR_PUSH1;
			`WR_PUSH1:
				wr_state_nxt = `WR_IDLE;
			default:
				wr_state_nxt = `WR_IDLE;
		endcase
	end

	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			wr_state_r <= `WR_IDLE;
			beat0_data_r <= {DATA_W{1'b0}};
			beat0_sel_r <= {LANES{1'b1}};
			beat1_data_r <= {DATA_W{1'b0}};
			beat1_sel_r <= {LANES{1'b1}};
			wr_addr_r <= {ADDR_W{1'b0}};
		end
		else
		begin
			wr_state_r <= wr_state_nxt;
			if (wr_state_r == `WR_IDLE && kpos_rise && !write_port_select_n)
			begin
				beat0_data_r <= write_data;
				beat0_sel_r <= lane_write_select_n;
			end
			if (wr_state_r == `WR_SECOND && kneg_rise)
			begin
				wr_addr_r <= address;
				beat1_data_r <= write_data;
				beat1_sel_r <= lane_write_select_n;
			end
		end
	end

	// An all-high beat is not queued; the burst still completes
	always @*
	begin
		push_valid = 1'b0;
		push_entry = {wr_addr_r, `BEAT_FIRST, beat0_sel_r, beat0_data_r};
		if (wr_state_r == `WR_PUSH0)
			push_valid = ~&beat0_sel_r;
		else if (wr_state_r == `WR_PUSH1)
		begin
			push_valid = ~&beat1_sel_r;
			push_entry = {wr_addr_r, `BEAT_SECOND, beat1_sel_r, beat1_data_r};
		end
	end

	// The pins cannot be stalled, so a full buffer loses the beat and says so
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			write_ready <= 1'b0;
			write_dropped <= 1'b0;
		end
		else
		begin
			write_ready <= push_ready;
			if (push_valid && !push_ready)
				write_dropped <= 1'b1;
		end
	end

	beat_fifo #(
		.WIDTH(ENT_W),
		.DEPTH(`FIFO_DEPTH),
		.PTR_W(`FIFO_PTR_W)
	) u_beat_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_entry),
		.out_valid(drain_valid),
		.out_ready(drain_ready),
		.out_data(drain_entry)
	);

	assign drain_idx = drain_entry[ENT_W-1:LANES+DATA_W];
	assign drain_sel = drain_entry[LANES+DATA_W-1:DATA_W];
	assign drain_data = drain_entry[DATA_W-1:0];

	// Lane partition follows DATA_W: nibbles, one 9-bit lane, or 9-bit lanes
	always @*
	begin
		lane_mask = {DATA_W{1'b0}};
		for (i = 0; i < DATA_W; i = i + 1)
			lane_mask[i] = ~drain_sel[i / LANE_W];
	end

	// Unselected lanes keep the stored bits
	assign merged = (drain_data & lane_mask) | (mem[drain_idx] & ~lane_mask);

	// Reads own the array on launch cycles; the buffer absorbs the stall
	assign drain_ready = ~rd_fetch;

	always @(posedge core_clk)
	begin
		if (drain_valid && drain_ready)
			mem[drain_idx] <= merged;
	end

	assign rd_start = kpos_rise & ~read_port_select_n;
	assign rd_fetch = ((rd_state_r == `RD_WORD0) & oneg_rise) |
		((rd_state_r == `RD_WORD1) & opos_rise);

	always @*
	begin
		rd_state_nxt = rd_state_r;
		case (rd_state_r)
			`RD_IDLE:
			begin
				if (rd_start)
					rd_state_nxt = `RD_ARM;
			end
			`RD_ARM:
			begin
				if (kpos_rise)
					rd_state_nxt = `RD_WORD0;
			end
			`RD_WORD0:
			begin
				if (oneg_rise)
					rd_state_nxt = `RD_WORD1;
			end
			`RD_WORD1:
			begin
				if (opos_rise)
					rd_state_nxt = `RD_TAIL;
			end
			`RD_TAIL:
			begin
				if (rd_start)
					rd_state_nxt = `RD_ARM;
				else if (oneg_rise)
					rd_state_nxt = `RD_IDLE;
			end
			default:
				rd_state_nxt = `RD_IDLE;
		endcase
	end

	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			rd_state_r <= `RD_IDLE;
			rd_addr_r <= {ADDR_W{1'b0}};
			read_data <= {DATA_W{1'b0}};
			read_data_oe <= 1'b0;
		end
		else
		begin
			rd_state_r <= rd_state_nxt;
			if ((rd_state_r == `RD_IDLE || rd_state_r == `RD_TAIL) && rd_start)
				rd_addr_r <= address;
			if (rd_state_r == `RD_WORD0 && oneg_rise)
			begin
				read_data <= mem[{rd_addr_r, `BEAT_FIRST}];
				read_data_oe <= 1'b1;
			end
			else if (rd_state_r == `RD_WORD1 && opos_rise)
				read_data <= mem[{rd_addr_r, `BEAT_SECOND}];
			else if (rd_state_r == `RD_TAIL && oneg_rise)
				read_data_oe <= 1'b0;
		end
	end
endmodule // burst_write_lane_masking
`default_nettype wire

// ==== bench/lane_mask_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module lane_mask_asserts #(
	parameter DATA_W = 18
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Watched pins
	input wire logic in_clk_pos,
	input wire logic in_clk_neg,
	input wire logic out_clk_pos,
	input wire logic out_clk_neg,
	input wire logic [DATA_W-1:0] read_data,
	input wire logic read_data_oe,
	input wire logic write_ready,
	input wire logic write_dropped
);
	// Launch clocks follow the strap taken at the first edge after reset
	logic strap_seen_r;
	logic single_mode_r;
	wire logic lpos;
	wire logic lneg;
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			strap_seen_r <= 1'b0;
			single_mode_r <= 1'b0;
		end
		else if (!strap_seen_r)
		begin
			strap_seen_r <= 1'b1;
			single_mode_r <= out_clk_pos & out_clk_neg;
		end
	end
	assign lpos = single_mode_r ? in_clk_pos : out_clk_pos;
	assign lneg = single_mode_r ? in_clk_neg : out_clk_neg;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_oe_power_up: assert property ($fell(reset) |-> !read_data_oe)
		else $error("read enable high after reset");
	chk_ready_power_up: assert property ($fell(reset) |=> write_ready && !write_dropped)
		else $error("write status wrong after reset");
	chk_data_on_rise: assert property ($changed(read_data) |->
		($past(lpos) && !$past(lpos, 2)) || ($past(lneg) && !$past(lneg, 2)))
		else $error("read data moved off a clock rise");
	chk_oe_rise_neg: assert property ($rose(read_data_oe) |-> lneg && $past(lneg))
		else $error("read enable rose outside negative phase");
	chk_oe_fall_neg: assert property ($fell(read_data_oe) |->
		$past(lneg) && !$past(lneg, 2))
		else $error("read enable fell off a negative rise");
	chk_oe_two_words: assert property ($rose(read_data_oe) |-> read_data_oe [*6])
		else $error("read enable too short for two words");
	chk_word_one_pos: assert property ($past(read_data_oe) && read_data_oe &&
		$changed(read_data) |-> $past(lpos) && !$past(lpos, 2))
		else $error("second word off a positive rise");
	chk_drop_sticky: assert property (write_dropped |=> write_dropped)
		else $error("drop flag cleared without reset");
endmodule // lane_mask_asserts
bind burst_write_lane_masking lane_mask_asserts #(.DATA_W(DATA_W)) u_lane_mask_asserts (.*);
`default_nettype wire

// ==== bench/ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Controller pins
	output logic in_clk_pos,
	output logic in_clk_neg,
	output logic write_port_select_n = 1'b1,
	output logic read_port_select_n = 1'b1,
	output logic [5:0] address = 6'h00,
	output logic [17:0] write_data = 18'h00000,
	output logic [1:0] lane_write_select_n = 2'h3
);
	logic [2:0] ph_r = 3'h7;
	logic run_r = 1'b0;
	// Both phases park low while stopped, for a clean restart
	assign in_clk_pos = run_r && ph_r < 3'h4;
	assign in_clk_neg = run_r && ph_r >= 3'h4;
	always @(negedge core_clk)
	begin
		run_r <= !reset;
		ph_r <= reset ? 3'h7 : ph_r + 3'h1;
	end
	// Drive just before the phase whose rise takes the value
	task sync(input logic [2:0] p);
		begin
			@(posedge core_clk);
			repeat (8) if (ph_r !== p) @(posedge core_clk);
			// Input clocks stuck: count it and end the run
			if (ph_r !== p)
			begin
				tb.failures++;
				tb.test_done;
			end
			@(negedge core_clk);
		end
	endtask
	task wr(input logic [5:0] a, input logic [17:0] d0, d1, input logic [1:0] s0, s1);
		begin
			sync(3'h7);
			write_port_select_n <= 1'b0;
			write_data <= d0;
			lane_write_select_n <= s0;
			sync(3'h3);
			write_port_select_n <= 1'b1;
			address <= a;
			write_data <= d1;
			lane_write_select_n <= s1;
			@(negedge core_clk);
			// Stale beat must not be mistaken for held data
			write_data <= ~d1;
			lane_write_select_n <= ~s1;
		end
	endtask
	task rd(input logic [5:0] a);
		begin
			sync(3'h7);
			read_port_select_n <= 1'b0;
			address <= a;
			sync(3'h3);
			read_port_select_n <= 1'b1;
			address <= ~a;
		end
	endtask
endmodule // ctrl_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	// Output clocks high strap single clock mode; dual mode lags the input pair
	logic dual_mode = 1'b0;
	logic [1:0] opos_lag = 2'h0;
	logic [1:0] oneg_lag = 2'h0;
	logic out_clk_pos, out_clk_neg;
	logic in_clk_pos, in_clk_neg, write_port_select_n, read_port_select_n;
	logic [5:0] address;
	logic [17:0] write_data, read_data;
	logic [1:0] lane_write_select_n;
	logic read_data_oe, write_ready, write_dropped;
	logic [17:0] shadow [0:63][0:1];
	int failures = 0;
	int n_checks = 0;
	always #12.5 core_clk = ~core_clk;
	always @(negedge core_clk)
	begin
		opos_lag <= {opos_lag[0], in_clk_pos};
		oneg_lag <= {oneg_lag[0], in_clk_neg};
	end
	assign out_clk_pos = dual_mode ? opos_lag[1] : 1'b1;
	assign out_clk_neg = dual_mode ? oneg_lag[1] : 1'b1;
	ctrl_model u_ctrl_model (.*);
	burst_write_lane_masking #(.DATA_W(18)) u_burst_write_lane_masking (.*);
	function automatic logic [17:0] merge(input logic [17:0] o, n, input logic [1:0] s);
		merge = {s[1] ? o[17:9] : n[17:9], s[0] ? o[8:0] : n[8:0]};
	endfunction
	task check(input logic [17:0] got, input logic [17:0] exp);
		begin
			n_checks++;
			if (got !== exp)
			begin
				failures++;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", n_checks, failures);
			if (failures == 0 && n_checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task write_burst(input logic [5:0] a, input logic [17:0] d0, d1, input logic [1:0] s0, s1);
		begin
			u_ctrl_model.wr(a, d0, d1, s0, s1);
			shadow[a][0] = merge(shadow[a][0], d0, s0);
			shadow[a][1] = merge(shadow[a][1], d1, s1);
		end
	endtask
	task read_back(input logic [5:0] a);
		int i;
		begin
			u_ctrl_model.rd(a);
			for (i = 0; i < 40 && read_data_oe !== 1'b1; i++)
				@(negedge core_clk);
			if (i == 40)
			begin
				failures++;
				test_done;
			end
			// First word one and a half input cycles after the request, two core_clk cycles later in dual mode
			check(18'(i), dual_mode ? 18'h0000B : 18'h00009);
			check(read_data, shadow[a][0]);
			repeat (4) @(negedge core_clk);
			check(read_data, shadow[a][1]);
			repeat (4) @(negedge core_clk);
			check({17'h0, read_data_oe}, 18'h0);
		end
	endtask
	task t_power_up;
		begin
			check({16'h0, read_data_oe, write_dropped}, 18'h0);
			check({17'h0, write_ready}, 18'h1);
		end
	endtask
	task t_full_burst;
		begin
			write_burst(6'h05, 18'h00000, 18'h3FFFF, 2'h0, 2'h0);
			write_burst(6'h06, 18'h15555, 18'h2AAAA, 2'h0, 2'h0);
			read_back(6'h05);
			read_back(6'h06);
		end
	endtask
	task t_lane_masks;
		logic [1:0] k;
		int j;
		begin
			for (j = 0; j < 4; j++)
			begin
				k = j[1:0];
				// Each beat gets the opposite pattern, all-high included
				write_burst(6'h05, {k, 7'h25, k, 7'h4B}, {~k, 7'h31, ~k, 7'h6E}, k, ~k);
				read_back(6'h05);
			end
			check({17'h0, write_dropped}, 18'h0);
		end
	endtask
	task t_dual_clock;
		begin
			// Second reset releases with the output clocks low: dual clock mode
			reset <= 1'b1;
			dual_mode <= 1'b1;
			repeat (3) @(negedge core_clk);
			reset <= 1'b0;
			repeat (3) @(negedge core_clk);
			t_power_up;
			write_burst(6'h06, 18'h2468A, 18'h13579, 2'h1, 2'h2);
			read_back(6'h06);
		end
	endtask
	initial
	begin
		repeat (3) @(negedge core_clk);
		reset <= 1'b0;
		repeat (3) @(negedge core_clk);
		t_power_up;
		t_full_burst;
		t_lane_masks;
		t_dual_clock;
		test_done;
	end
endmodule // tb
`default_nettype wire
